// ==== hdl/iorc_buf.sv ====
`timescale 1ns/10ps
// Two-entry skid buffer; read data survives a stalled receiver
module iorc_buf
  import iorc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [11:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [11:0] out_data
);
  logic [11:0] mem [IORC_BUF_DEPTH];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  logic        next_wr_ptr;
  logic        next_rd_ptr;
  logic [1:0]  next_count;
  logic        push;
  logic        pop;

  // Pointer and occupancy bookkeeping
  always_comb begin
    push        = in_valid && (count != 2'h2);
    pop         = (count != 2'h0) && out_ready;
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count  = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; valid guards it
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
endmodule : iorc_buf

// ==== hdl/iorc_pkg.sv ====
package iorc_pkg;
  // Width of one register stage group
  localparam int unsigned IORC_WIDTH = 12;
  // Control codes on the register bus
  typedef enum logic [1:0] {
    IORC_CC_NONE  = 2'h0,
    IORC_CC_SHIFT = 2'h1,
    IORC_CC_INPUT = 2'h2,
    IORC_CC_OUTPUT = 2'h3
  } iorc_code_t;
  // Reset values
  localparam logic [11:0] IORC_OUT_RST = 12'h000;
  localparam logic [11:0] IORC_REG_RST = 12'h000;
  // Word clock stretch of the shift pulse, in word-clock periods
  localparam int unsigned IORC_PULSE_WORDS = 1;
  // Synchroniser depth for pins and the word clock
  localparam int unsigned IORC_SYNC_STAGES = 2;
  // Buffer depth on the read-data path
  localparam int unsigned IORC_BUF_DEPTH = 2;
endpackage : iorc_pkg

// ==== hdl/iorc_sync.sv ====
`timescale 1ns/10ps
// Two-stage synchroniser for a group of asynchronous levels
module iorc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync_out;

  // First stage is read only by the second
  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule : iorc_sync

// ==== hdl/iorc_top.sv ====
`timescale 1ns/10ps
// What the document asks of this block, its program and its peripheral
// [R1] Input instruction captures all 12 input lines, forwards selected bits
// [R2] Input lines are asynchronous; synchronised before any use
// [R3] Each input instruction emits a shift pulse so the peripheral advances
// [R4] Peripheral presents 2 to 17 bit serial words on one line
// [R5] Program raises an output channel to announce a serial transfer
// [R6] Output buffer loads from register on word clock, output command only
// [R7] Output levels hold steady until the next output command
// [R8] Every stage has one input and one output channel
// [R9] No readback of the output buffer; writes replace all twelve bits
// [R10] Software keeps a memory copy of commands and masks before output
// [R11] Pulsed resets are made by program set then clear
// [R12] Serial command uses a mode channel and a data channel
// [R13] Shift pulse on every input or output instruction
// [R14] Comparator results are plain inputs read by input instructions
// [R15] Program does successive approximation using comparator inputs
// [R16] Other instructions use register as scratch, outputs unchanged
// [R17] Bus distinguishes shift, input and output control codes
// [R18] Shift pulse lasts one word time, once per qualifying instruction
module iorc_top
  import iorc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        word_clock,
  input  wire logic [1:0]  ctrl_code,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire logic [11:0] write_data,
  input  wire logic [11:0] select_mask,
  output logic             acc_valid,
  input  wire logic        acc_ready,
  output logic      [11:0] acc_data,
  output logic      [11:0] scratch_data,
  input  wire logic [11:0] chan_in,
  output logic      [11:0] chan_out,
  output logic             shift_pulse
);
  typedef enum logic [2:0] {
    IORC_IDLE = 3'b001,
    IORC_WAIT = 3'b010,
    IORC_EXEC = 3'b100
  } iorc_state_t;

  iorc_state_t state;
  iorc_state_t next_state;
  iorc_code_t  code_held;
  iorc_code_t  next_code_held;
  logic [11:0] data_held;
  logic [11:0] next_data_held;
  logic [11:0] mask_held;
  logic [11:0] next_mask_held;
  logic [11:0] shift_reg;
  logic [11:0] next_shift_reg;
  logic [11:0] out_buf;
  logic [11:0] next_out_buf;
  logic        pulse;
  logic        next_pulse;
  logic        pulse_armed;
  logic        next_pulse_armed;
  logic [11:0] pins_sync;
  logic        wclk_sync;
  logic        wclk_prev;
  logic        wclk_rise;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic [11:0] buf_out_data;
  logic        acc_vld;
  logic        next_acc_vld;
  logic [11:0] next_acc_data;
  logic        acc_take;

  // Pins and the word clock are outside our domain
  iorc_sync #(.W(IORC_WIDTH)) u_pin_sync ( // [R2]
    .clock    (clock),
    .rst      (rst),
    .async_in (chan_in),
    .sync_out (pins_sync)
  );

  iorc_sync #(.W(1)) u_wclk_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (word_clock),
    .sync_out (wclk_sync)
  );

  // Word-clock rising edge, taken from the synchronised copy only
  always_ff @(posedge clock) begin
    if (rst) begin
      wclk_prev <= 1'b0;
    end else begin
      wclk_prev <= wclk_sync;
    end
  end
  assign wclk_rise = wclk_sync && !wclk_prev;

  // Ready only when idle and the read buffer can take a word
  assign instr_ready = (state == IORC_IDLE) && buf_in_ready;

  // Instruction sequencer: accepts in an idle cycle with read-buffer room, executes only after a word-clock edge
  always_comb begin
    next_state     = state;
    next_code_held = code_held;
    next_data_held = data_held;
    next_mask_held = mask_held;
    next_shift_reg = shift_reg;
    next_out_buf   = out_buf; // [R7] holds until an output command
    buf_in_valid   = 1'b0;
    unique case (state)
      IORC_IDLE: begin
        if (instr_valid && instr_ready) begin
          next_code_held = iorc_code_t'(ctrl_code); // [R17]
          next_data_held = write_data;
          next_mask_held = select_mask;
          next_state     = IORC_WAIT;
        end
      end
      IORC_WAIT: begin
        if (wclk_rise) begin
          next_state = IORC_EXEC;
        end
      end
      IORC_EXEC: begin
        next_state = IORC_IDLE;
        unique case (code_held)
          IORC_CC_INPUT: begin
            // All 12 lines captured, comparators included
            next_shift_reg = pins_sync; // [R1] [R14] [R8]
            buf_in_valid   = 1'b1;
          end
          IORC_CC_OUTPUT: begin
            // Whole word replaces buffer; no path back out
            next_shift_reg = data_held;
            next_out_buf   = data_held; // [R6] [R9] [R12]
          end
          IORC_CC_SHIFT: begin
            // Scratch use; outputs untouched
            next_shift_reg = data_held; // [R16]
          end
          IORC_CC_NONE: begin
            next_shift_reg = data_held; // [R16]
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= IORC_IDLE;
      code_held <= IORC_CC_NONE;
      data_held <= IORC_REG_RST;
      mask_held <= IORC_REG_RST;
      shift_reg <= IORC_REG_RST;
      out_buf   <= IORC_OUT_RST;
    end else begin
      state     <= next_state;
      code_held <= next_code_held;
      data_held <= next_data_held;
      mask_held <= next_mask_held;
      shift_reg <= next_shift_reg;
      out_buf   <= next_out_buf;
    end
  end

  // Shift pulse: raised at the instruction's word edge, dropped at the next
  // one, so it spans one word time and never repeats while idle
  always_comb begin
    next_pulse       = pulse;
    next_pulse_armed = pulse_armed;
    if (state == IORC_EXEC && (code_held == IORC_CC_INPUT ||
        code_held == IORC_CC_OUTPUT)) begin
      next_pulse       = 1'b1; // [R3] [R13]
      next_pulse_armed = 1'b1;
    end else if (pulse_armed && wclk_rise) begin
      next_pulse       = 1'b0; // [R18]
      next_pulse_armed = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse       <= 1'b0;
      pulse_armed <= 1'b0;
    end else begin
      pulse       <= next_pulse;
      pulse_armed <= next_pulse_armed;
    end
  end

  // Selected bits buffered so a stalled accumulator loses nothing
  iorc_buf u_acc_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (pins_sync & mask_held), // [R1]
    .out_valid (buf_out_valid),
    .out_ready (acc_take),
    .out_data  (buf_out_data)
  );

  // Output stage: valid and data leave flops together, so the receiver may
  // take acc_data in any cycle in which acc_valid stands; costs one entry
  assign acc_take = !acc_vld || acc_ready;

  always_comb begin
    next_acc_vld  = acc_vld;
    next_acc_data = acc_data;
    if (buf_out_valid && acc_take) begin
      next_acc_vld  = 1'b1; // [R1]
      next_acc_data = buf_out_data;
    end else if (acc_ready) begin
      next_acc_vld  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_vld  <= 1'b0;
      acc_data <= IORC_REG_RST;
    end else begin
      acc_vld  <= next_acc_vld;
      acc_data <= next_acc_data;
    end
  end
  assign acc_valid    = acc_vld;
  assign chan_out     = out_buf; // [R7] [R8]
  assign scratch_data = shift_reg;
  assign shift_pulse  = pulse;

  // Output channels move only one cycle after an output execution
  property p_out_hold;
    @(posedge clock) disable iff (rst)
      !(state == IORC_EXEC && code_held == IORC_CC_OUTPUT)
      |=> $stable(chan_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs moved"); // [R6]

  property p_out_load;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC && code_held == IORC_CC_OUTPUT)
      |=> chan_out == $past(data_held);
  endproperty
  a_out_load: assert property (p_out_load) else $error("bad load"); // [R9]

  property p_in_cap;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC && code_held == IORC_CC_INPUT)
      |=> scratch_data == $past(pins_sync);
  endproperty
  a_in_cap: assert property (p_in_cap) else $error("no capture"); // [R1]

  property p_pulse_io;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC && (code_held == IORC_CC_INPUT ||
       code_held == IORC_CC_OUTPUT)) |=> shift_pulse;
  endproperty
  a_pulse_io: assert property (p_pulse_io) else $error("no pulse"); // [R13]

  property p_pulse_shift;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC && code_held == IORC_CC_SHIFT && !pulse_armed)
      |=> !$rose(shift_pulse);
  endproperty
  a_pulse_shift: assert property (p_pulse_shift) // [R16]
    else $error("pulse on scratch");

  sequence s_pulse_up;
    $rose(shift_pulse);
  endsequence
  sequence s_pulse_down;
    !shift_pulse;
  endsequence
  // Once up, the pulse only drops at a word edge
  property p_pulse_len;
    @(posedge clock) disable iff (rst)
      (shift_pulse && !wclk_rise) |=> shift_pulse;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("short pulse"); // [R18]

  property p_pulse_end;
    @(posedge clock) disable iff (rst)
      (pulse && wclk_rise && state != IORC_EXEC) |=> s_pulse_down;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("long pulse"); // [R18]

  property p_rd_pulse;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC && code_held == IORC_CC_INPUT)
      |=> s_pulse_up or (shift_pulse && $past(shift_pulse));
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("no read pulse"); // [R3]

  property p_wait_edge;
    @(posedge clock) disable iff (rst)
      (state == IORC_EXEC) |-> $past(wclk_rise);
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("off word edge"); // [R6]

  // A word offered to the accumulator stays put until it is taken
  property p_acc_hold;
    @(posedge clock) disable iff (rst)
      (acc_valid && !acc_ready) |=> acc_valid && $stable(acc_data);
  endproperty
  a_acc_hold: assert property (p_acc_hold) // [R1]
    else $error("accumulator word lost");
endmodule : iorc_top

// ==== test/iorc_peer.sv ====
`timescale 1ns/10ps
// Experiment on the channel side: bilevel levels plus one serial line
module iorc_peer #(
  parameter int unsigned WORD_BITS = 5
) (
  input  wire logic                 clock,
  input  wire logic                 shift_pulse,
  input  wire logic [11:0]          chan_out,
  input  wire logic [11:0]          levels,
  input  wire logic [WORD_BITS-1:0] word,
  output logic      [11:0]          chan_in
);
  logic       sp_q   = 1'b0;
  logic       mode_q = 1'b0;
  logic [4:0] idx    = 5'h00;
  logic       bit_now;
  // Mode must already be up, so the pulse of the mode write is not a shift
  always @(posedge clock) begin
    sp_q   <= shift_pulse;
    mode_q <= chan_out[11];
    if (!chan_out[11]) idx <= 5'h00;
    else if (shift_pulse && !sp_q && mode_q) idx <= idx + 5'h01;
  end
  // Word sent MSB first on stage 0, length 2 to 17 bits
  // Past the last bit the line rests low instead of going unknown
  assign bit_now = (idx < WORD_BITS) ? word[WORD_BITS-1-idx] : 1'b0;
  assign chan_in = {levels[11:1], bit_now};
endmodule : iorc_peer

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import iorc_pkg::*;
  logic        clock;
  logic        rst;
  logic        word_clock;
  logic [1:0]  ctrl_code;
  logic        instr_valid;
  logic        instr_ready;
  logic [11:0] write_data;
  logic [11:0] select_mask;
  logic        acc_valid;
  logic        acc_ready;
  logic [11:0] acc_data;
  logic [11:0] scratch_data;
  logic [11:0] chan_in;
  logic [11:0] chan_out;
  logic        shift_pulse;
  logic [11:0] levels;
  logic        sp_q = 1'b0;
  int          pulses = 0;
  logic [11:0] cmd_copy = 12'h000;
  int          error_cnt;
  int          samples_checked;
  localparam logic [4:0] WORD = 5'h16;
  iorc_top u_iorc_top (.clock(clock), .rst(rst), .word_clock(word_clock),
    .ctrl_code(ctrl_code), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .write_data(write_data),
    .select_mask(select_mask), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .acc_data(acc_data),
    .scratch_data(scratch_data), .chan_in(chan_in), .chan_out(chan_out),
    .shift_pulse(shift_pulse));
  iorc_peer #(.WORD_BITS(5)) u_iorc_peer (.clock(clock),
    .shift_pulse(shift_pulse), .chan_out(chan_out), .levels(levels),
    .word(WORD), .chan_in(chan_in));
  // Clocks: word clock unrelated in phase to the system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    word_clock = 1'b0;
    #37;
    forever #100 word_clock = ~word_clock;
  end
  // Count rising edges of the shift pulse
  always @(posedge clock) begin
    sp_q <= shift_pulse;
    if (shift_pulse === 1'b1 && sp_q === 1'b0) pulses <= pulses + 1;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Hold the request until taken; then allow execution and pulse to finish
  task automatic issue(input logic [1:0] c, input logic [11:0] w,
                       input logic [11:0] m);
    int n;
    n = 0;
    ctrl_code   <= c;
    write_data  <= w;
    select_mask <= m;
    instr_valid <= 1'b1;
    @(negedge clock);
    while (instr_ready !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) chk(12'hbad, 12'h000);
    @(posedge clock);
    instr_valid <= 1'b0;
    repeat (24) @(posedge clock);
  endtask : issue
  // Wait for a word, compare it while it stands, then take it
  task automatic pop(input logic [11:0] exp);
    int n;
    n = 0;
    @(negedge clock);
    while (acc_valid !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) chk(12'hbad, 12'h000);
    chk(acc_data, exp);
    @(posedge clock);
    acc_ready <= 1'b1;
    @(posedge clock);
    acc_ready <= 1'b0;
  endtask : pop
  task automatic t_output;
    int p;
    p = pulses;
    cmd_copy = 12'h3a5;
    issue(2'h3, cmd_copy, 12'h000);
    chk(chan_out, 12'h3a5);
    issue(2'h1, 12'hfff, 12'h000);
    chk(scratch_data, 12'hfff);
    issue(2'h0, 12'h0c3, 12'h000);
    repeat (40) @(posedge clock);
    chk(chan_out, 12'h3a5);
    chk(12'(pulses - p), 12'h001);
    $display("test output done");
  endtask : t_output
  task automatic t_input;
    int p;
    p = pulses;
    levels <= 12'h5a7;
    issue(2'h2, 12'h000, 12'hffe);
    pop(12'h5a6);
    chk(scratch_data, 12'h5a7);
    chk(12'(pulses - p), 12'h001);
    $display("test input done");
  endtask : t_input
  task automatic t_serial;
    cmd_copy = cmd_copy | 12'h800;
    issue(2'h3, cmd_copy, 12'h000);
    for (int i = 4; i >= 0; i--) begin
      issue(2'h2, 12'h000, 12'h001);
      pop({11'h000, WORD[i]});
    end
    cmd_copy = cmd_copy & 12'h7ff;
    issue(2'h3, cmd_copy, 12'h000);
    chk(chan_out, 12'h3a5);
    $display("test serial done");
  endtask : t_serial
  task automatic t_buffer;
    levels <= 12'hc3c;
    issue(2'h2, 12'h000, 12'h0f0);
    issue(2'h2, 12'h000, 12'h00f);
    issue(2'h2, 12'h000, 12'hf00);
    chk({11'h000, instr_ready}, 12'h000);
    pop(12'h030);
    pop(12'h00d);
    pop(12'hc00);
    @(negedge clock);
    chk({10'h000, acc_valid, instr_ready}, 12'h001);
    $display("test buffer done");
  endtask : t_buffer
  // Successive approximation: trial bit out, comparator in, keep or drop
  task automatic t_convert;
    logic [7:0] analog;
    logic [7:0] dac;
    logic       cmp;
    analog = 8'h9c;
    dac    = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      dac[b] = 1'b1;
      issue(2'h3, {4'h0, dac}, 12'h000);
      cmp = (analog >= dac);
      levels <= {6'h00, (analog >= chan_out[7:0]), 5'h00};
      issue(2'h2, 12'h000, 12'h020);
      pop({6'h00, cmp, 5'h00});
      dac[b] = cmp;
    end
    issue(2'h3, {4'h0, dac}, 12'h000);
    chk(chan_out, {4'h0, analog});
    $display("test convert done");
  endtask : t_convert
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    // Watchdog: nearly five times the length of a clean run
    #(25 * 4000);
    error_cnt++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    ctrl_code = 2'h0;
    instr_valid = 1'b0;
    write_data = 12'h000;
    select_mask = 12'h000;
    acc_ready = 1'b0;
    levels = 12'h000;
    error_cnt = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(chan_out | scratch_data, 12'h000);
    chk({9'h000, shift_pulse, acc_valid, instr_ready}, 12'h001);
    @(posedge clock);
    t_output();
    t_input();
    t_serial();
    t_buffer();
    t_convert();
    final_report();
  end
endmodule : testbench
